// ==== hdl/ssem_top.sv ====
// Purpose: Sleep-state dependent masking of input and fan tachometer error events
// Assumes: Error events are single-cycle or level signals on clk_sys
// Notes:   Registers reached over AXI4-Lite, byte address is four times the index
// Operation
// RULE1: Eight-bit read/write S1 input mask, resets to all ones, bit n masks input n.
// RULE2: Input mask bits act only while the sleep state field reads S1.
// RULE3: S1 fan mask has four writable low bits, upper bits read zero, resets 0x0f.
// RULE4: Fan mask bit set and state S1 suppresses that fan's error events.
// RULE5: Field decode 00 S0, 01 S1, 10 S3, 11 S4/5; S4/5 may enter automatically.
//
// The AXI4-Lite slave port is this design's own decision.
`include "ssem_defs.svh"

module ssem_top (
    // Clock and reset
    input  wire logic               clk_sys,
    input  wire logic               rst,
    // AXI4-Lite write address and data
    input  wire logic [11:0]        s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    // AXI4-Lite read
    input  wire logic [11:0]        s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready,
    // Automatic entry into S4/5 (pulse)
    input  wire logic               auto_s45_req,
    // Raw and masked error events
    input  wire ssem_pkg::ssem_err_s err_in,
    output ssem_pkg::ssem_err_s     err_out,
    // Current sleep state
    output ssem_pkg::ssem_sleep_e   sleep_state
);
    import ssem_pkg::*;

    logic [1:0]  sleep_reg;
    logic [7:0]  s1_input_reg;
    logic [3:0]  s1_fan_reg;
    logic [11:0] awaddr_reg;
    logic        aw_held_reg;
    logic [31:0] wdata_reg;
    logic        w_held_reg;
    logic        bvalid_reg;
    logic [1:0]  bresp_reg;
    logic        rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0]  rresp_reg;
    ssem_err_s   err_reg;

    // Word index of a byte address; the low two address bits are ignored
    function automatic logic [7:0] ssem_index(input logic [11:0] addr);
        return addr[9:2];
    endfunction

    // Write path: address and data latched independently, response after both
    wire       w_fire    = aw_held_reg && w_held_reg && !bvalid_reg;
    wire [7:0] w_idx     = ssem_index(awaddr_reg);
    // Only byte lane 0 carries register bits, so only its strobe gates a write
    wire       w_sleep   = w_fire && w_idx == `SSEM_IDX_SLEEP_CTRL && awaddr_reg[11:10] == 2'h0;
    wire       w_input   = w_fire && w_idx == `SSEM_IDX_S1_INPUT && awaddr_reg[11:10] == 2'h0;
    wire       w_fan     = w_fire && w_idx == `SSEM_IDX_S1_FAN && awaddr_reg[11:10] == 2'h0;
    wire       w_mapped  = w_sleep || w_input || w_fan;
    logic [3:0] wstrb_reg;
    wire       w_byte0   = wstrb_reg[0];

    assign s_axi_awready = !aw_held_reg;
    assign s_axi_wready  = !w_held_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;

    // Capture write address
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            aw_held_reg <= 1'b0;
            awaddr_reg  <= 12'h000;
        end else if (s_axi_awvalid && !aw_held_reg) begin
            aw_held_reg <= 1'b1;
            awaddr_reg  <= s_axi_awaddr;
        end else if (w_fire) begin
            aw_held_reg <= 1'b0;
        end
    end

    // Capture write data
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            w_held_reg <= 1'b0;
            wdata_reg  <= 32'h0000_0000;
            wstrb_reg  <= 4'h0;
        end else if (s_axi_wvalid && !w_held_reg) begin
            w_held_reg <= 1'b1;
            wdata_reg  <= s_axi_wdata;
            wstrb_reg  <= s_axi_wstrb;
        end else if (w_fire) begin
            w_held_reg <= 1'b0;
        end
    end

    // Write response
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= `SSEM_RESP_OKAY;
        end else if (w_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= w_mapped ? `SSEM_RESP_OKAY : `SSEM_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // Sleep state field; an automatic S4/5 request wins over a software write
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sleep_reg <= 2'(`SSEM_RST_SLEEP_CTRL & 8'h03);
        end else if (auto_s45_req) begin
            sleep_reg <= SSEM_S45; // [RULE5]
        end else if (w_sleep && w_byte0) begin
            sleep_reg <= wdata_reg[`SSEM_SLEEP_MSB:`SSEM_SLEEP_LSB];
        end
    end

    // S1 mask registers
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s1_input_reg <= `SSEM_RST_S1_INPUT; // [RULE1]
            s1_fan_reg   <= `SSEM_RST_S1_FAN;   // [RULE3]
        end else begin
            if (w_input && w_byte0) begin
                s1_input_reg <= wdata_reg[7:0]; // [RULE1]
            end
            if (w_fan && w_byte0) begin
                s1_fan_reg <= wdata_reg[`SSEM_FAN_MSB:0]; // [RULE3]
            end
        end
    end

    // Read path
    wire [7:0]  r_idx    = ssem_index(s_axi_araddr);
    wire        r_hi_ok  = s_axi_araddr[11:10] == 2'h0;
    wire        r_sleep  = r_hi_ok && r_idx == `SSEM_IDX_SLEEP_CTRL;
    wire        r_input  = r_hi_ok && r_idx == `SSEM_IDX_S1_INPUT;
    wire        r_fan    = r_hi_ok && r_idx == `SSEM_IDX_S1_FAN;
    wire [31:0] r_word   = r_sleep ? {30'h0, sleep_reg}
                         : r_input ? {24'h00_0000, s1_input_reg}
                         : r_fan   ? {28'h000_0000, s1_fan_reg} // [RULE3]
                         : 32'h0000_0000;
    wire        r_fire   = s_axi_arvalid && !rvalid_reg;

    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;

    // Read data and response
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0000_0000;
            rresp_reg  <= `SSEM_RESP_OKAY;
        end else if (r_fire) begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= r_word;
            rresp_reg  <= (r_sleep || r_input || r_fan) ? `SSEM_RESP_OKAY : `SSEM_RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    // Masking: only the S1 state applies the S1 masks
    wire       in_s1      = sleep_reg == SSEM_S1;                       // [RULE5]
    wire [7:0] input_gate = in_s1 ? ~s1_input_reg : 8'hff;              // [RULE2]
    wire [3:0] fan_gate   = in_s1 ? ~s1_fan_reg : 4'hf;                 // [RULE4]
    ssem_err_s err_next;
    assign err_next = {err_in.general_purpose_input & input_gate,       // [RULE1]
                       err_in.fan & fan_gate};                          // [RULE4]

    // Registered masked errors
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            err_reg <= '0;
        end else begin
            err_reg <= err_next;
        end
    end

    assign err_out     = err_reg;
    assign sleep_state = ssem_sleep_e'(sleep_reg);

    a_input_mask_s1: assert property (@(posedge clk_sys) disable iff (rst) // [RULE2]
        (sleep_reg == 2'h1) |=> (err_out.general_purpose_input
            == ($past(err_in.general_purpose_input) & ~$past(s1_input_reg))))
        else $error("Input errors not masked in S1");
    a_input_pass_other: assert property (@(posedge clk_sys) disable iff (rst) // [RULE2]
        (sleep_reg != 2'h1) |=> (err_out.general_purpose_input
            == $past(err_in.general_purpose_input)))
        else $error("Input errors masked outside S1");
    a_fan_mask_s1: assert property (@(posedge clk_sys) disable iff (rst) // [RULE4]
        (sleep_reg == 2'h1) |=> (err_out.fan == ($past(err_in.fan) & ~$past(s1_fan_reg))))
        else $error("Fan errors not masked in S1");
    a_fan_pass_other: assert property (@(posedge clk_sys) disable iff (rst) // [RULE4]
        (sleep_reg != 2'h1) |=> (err_out.fan == $past(err_in.fan)))
        else $error("Fan errors masked outside S1");
    a_input_write_takes: assert property (@(posedge clk_sys) disable iff (rst) // [RULE1]
        (w_input && wstrb_reg[0]) |=> (s1_input_reg == $past(wdata_reg[7:0])))
        else $error("Input mask write lost");
    a_fan_read_reserved: assert property (@(posedge clk_sys) disable iff (rst) // [RULE3]
        (r_fire && r_fan) |=> (rdata_reg[31:4] == 28'h000_0000
            && rdata_reg[3:0] == $past(s1_fan_reg)))
        else $error("Fan mask read wrong");
    a_auto_s45_entry: assert property (@(posedge clk_sys) disable iff (rst) // [RULE5]
        auto_s45_req |=> (sleep_state == SSEM_S45))
        else $error("Automatic S4/5 entry missed");
    a_write_resp_time: assert property (@(posedge clk_sys) disable iff (rst)
        w_fire |=> s_axi_bvalid)
        else $error("Write response late");
endmodule // ssem_top

// ==== hdl/ssem_defs.svh ====
// Purpose: Register offsets, field positions and reset values of the sleep mask block
// Assumes: Byte addresses on a 32-bit AXI4-Lite bus, one aligned word per register
// Notes:   The printed offsets are not multiples of four, so they are kept as indices
`ifndef SSEM_DEFS_SVH
`define SSEM_DEFS_SVH

`define SSEM_IDX_SLEEP_CTRL   8'he4
`define SSEM_IDX_S1_INPUT     8'he5
`define SSEM_IDX_S1_FAN       8'he6
`define SSEM_RST_SLEEP_CTRL   8'h07
`define SSEM_RST_S1_INPUT     8'hff
`define SSEM_RST_S1_FAN       4'hf
`define SSEM_SLEEP_LSB        0
`define SSEM_SLEEP_MSB        1
`define SSEM_FAN_MSB          3
`define SSEM_RESP_OKAY        2'h0
`define SSEM_RESP_SLVERR      2'h2

`endif

// ==== hdl/ssem_pkg.sv ====
// Purpose: Types shared by the sleep mask block
// Assumes: Constants live in ssem_defs.svh
// Notes:   Sleep states follow the two-bit sleep state field encoding
package ssem_pkg;
    typedef enum logic [1:0] {
        SSEM_S0   = 2'h0,
        SSEM_S1   = 2'h1,
        SSEM_S3   = 2'h2,
        SSEM_S45  = 2'h3
    } ssem_sleep_e;

    typedef struct packed {
        logic [7:0] general_purpose_input;
        logic [3:0] fan;
    } ssem_err_s;
endpackage

// ==== bench/ssem_top_tb_top.sv ====
// Purpose: Self-checking bench for the sleep state error masking block
// Assumes: Byte address is four times the register index, one word each
// Notes:   Random masks and errors come from an LFSR seeded with 32'hfb67
`include "ssem_defs.svh"

module ssem_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import ssem_pkg::*;

    localparam logic [11:0] A_SLP = {2'h0, `SSEM_IDX_SLEEP_CTRL, 2'h0};
    localparam logic [11:0] A_IN  = {2'h0, `SSEM_IDX_S1_INPUT, 2'h0};
    localparam logic [11:0] A_FAN = {2'h0, `SSEM_IDX_S1_FAN, 2'h0};
    localparam logic [11:0] A_BAD = 12'h3a0;

    logic        clk_sys = 1'b0, rst = 1'b1;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, seed = 32'hfb67;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, auto_s45_req = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [7:0]  mi;
    logic [3:0]  mf;
    ssem_err_s   err_in = '0, err_out, e;
    ssem_sleep_e sleep_state;
    int          errors = 0, compares = 0, cycles = 0;

    ssem_top i_ssem_top (.clk_sys(clk_sys), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .auto_s45_req(auto_s45_req), .err_in(err_in),
        .err_out(err_out), .sleep_state(sleep_state));

    // Clock and cycle ceiling
    always #25 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors = errors + 1;
            tally_and_finish();
        end
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Masking applies only in S1
    function automatic ssem_err_s exp_err(input ssem_err_s v, input logic [1:0] st,
                                          input logic [7:0] m8, input logic [3:0] m4);
        exp_err = v;
        if (st == SSEM_S1) begin
            exp_err.general_purpose_input = v.general_purpose_input & ~m8;
            exp_err.fan = v.fan & ~m4;
        end
    endfunction

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares = compares + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Write: offer address and data, drop each when taken, wait for response
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] st,
                      input logic [1:0] er);
        @(posedge clk_sys);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= st;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        forever begin
            @(posedge clk_sys);
            if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) break;
        end
        s_axi_bready <= 1'b0;
        chk("bresp", 32'(er), 32'(s_axi_bresp));
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge clk_sys);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        forever begin
            @(posedge clk_sys);
            if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) break;
        end
        s_axi_rready <= 1'b0;
        chk("rdata", ed, s_axi_rdata);
        chk("rresp", 32'(er), 32'(s_axi_rresp));
    endtask

    task automatic tally_and_finish();
        if (errors == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        rd(A_IN, 32'(`SSEM_RST_S1_INPUT), `SSEM_RESP_OKAY);
        rd(A_FAN, 32'(`SSEM_RST_S1_FAN), `SSEM_RESP_OKAY);
        rd(A_SLP, 32'(`SSEM_RST_SLEEP_CTRL & 8'h03), `SSEM_RESP_OKAY);
        chk("sleep", 32'h3, 32'(sleep_state));
        rd(A_BAD, 32'h0, `SSEM_RESP_SLVERR);
        rd(A_SLP | 12'h400, 32'h0, `SSEM_RESP_SLVERR);
        wr(A_BAD, 32'hffff_ffff, 4'hf, `SSEM_RESP_SLVERR);
        wr(A_FAN, 32'h0000_00f5, 4'hf, `SSEM_RESP_OKAY);
        rd(A_FAN, 32'h5, `SSEM_RESP_OKAY);
        wr(A_IN, 32'h0000_0000, 4'he, `SSEM_RESP_OKAY);
        rd(A_IN, 32'hff, `SSEM_RESP_OKAY);
        // Every sleep state with random masks and random error patterns
        for (int s = 0; s < 4; s++) begin
            seed = lfsr(seed);
            mi = seed[7:0];
            mf = seed[11:8];
            wr(A_IN, {seed[31:8], mi}, 4'hf, `SSEM_RESP_OKAY);
            wr(A_FAN, {28'h0, mf}, 4'hf, `SSEM_RESP_OKAY);
            wr(A_SLP, 32'(s), 4'hf, `SSEM_RESP_OKAY);
            rd(A_IN, 32'(mi), `SSEM_RESP_OKAY);
            chk("sleep", 32'(s), 32'(sleep_state));
            for (int k = 0; k < 6; k++) begin
                @(posedge clk_sys);
                seed = lfsr(seed);
                e = (k == 0) ? 12'hfff : seed[19:8];
                err_in <= e;
                @(posedge clk_sys);
                #1;
                chk("err_out", 32'(exp_err(e, s[1:0], mi, mf)), 32'(err_out));
            end
        end
        // Automatic entry into S4/5 from S1
        wr(A_SLP, 32'h1, 4'hf, `SSEM_RESP_OKAY);
        @(posedge clk_sys);
        auto_s45_req <= 1'b1;
        @(posedge clk_sys);
        auto_s45_req <= 1'b0;
        #1;
        chk("sleep", 32'h3, 32'(sleep_state));
        tally_and_finish();
    end
endmodule // ssem_top_tb_top
